// [inc/fecb_pkg.sv]
// constants and types shared by the flash ecc engine
package fecb_pkg;
    // ************
    // stream layout of one sector
    // ************
    localparam int          FECB_WORD_W      = 16;
    localparam int          FECB_IDX_W       = 9;
    localparam logic [8:0]  FECB_MARK_IDX    = 9'h100;
    localparam logic [8:0]  FECB_SP_DATA0    = 9'h101;
    localparam logic [8:0]  FECB_SP_DATA1    = 9'h102;
    localparam logic [8:0]  FECB_SP_ECC0     = 9'h103;
    localparam logic [8:0]  FECB_SP_ECC1     = 9'h104;
    localparam logic [8:0]  FECB_SP_ECC2     = 9'h105;
    localparam logic [8:0]  FECB_LAST_IDX    = 9'h107;
    localparam logic [8:0]  FECB_IDX_RST     = 9'h000;
    // ************
    // configuration, codes and marks
    // ************
    localparam int          FECB_BYPASS_BIT  = 9;
    localparam int          FECB_MAIN_CODE_W = 24;
    localparam int          FECB_SPARE_CODE_W = 10;
    localparam int          FECB_MAIN_PAIRS  = 12;
    localparam int          FECB_SPARE_PAIRS = 5;
    localparam logic [15:0] FECB_ERASED      = 16'hffff;
    localparam logic [7:0]  FECB_PAD8        = 8'hff;
    localparam logic [5:0]  FECB_PAD6        = 6'h3f;
    localparam logic [5:0]  FECB_MARK_PAGES  = 6'h02;
    localparam logic [1:0]  FECB_MARK_SECTOR = 2'h0;
    localparam logic [8:0]  FECB_BLOCK0      = 9'h000;
    localparam logic [3:0][15:0] FECB_BITSEL =
        {16'hff00, 16'hf0f0, 16'hcccc, 16'haaaa};
    // ************
    // status encoding
    // ************
    localparam logic [1:0]  FECB_ST_NONE     = 2'h0;
    localparam logic [1:0]  FECB_ST_ONE      = 2'h1;
    localparam logic [1:0]  FECB_ST_TWO      = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_XFER,
        S_CHECK,
        S_FIX,
        S_DRAIN
    } fecb_state_t;
endpackage

// [rtl/fecb_code_acc.sv]
// running main and spare ecc code accumulator for one sector
`timescale 1ns/1ps
module fecb_code_acc
    import fecb_pkg::*;
(
    input  wire logic        clk,        // core clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic        clear,      // restart codes for new sector
    input  wire logic        en,         // accumulate this word
    input  wire logic [15:0] word,       // data word
    input  wire logic [8:0]  idx,        // word index in sector
    output logic      [23:0] mainCode,   // main area code
    output logic      [9:0]  spareCode   // spare data code
);
    logic [7:0]  bitPar;
    logic        wordPar;
    logic [23:0] mainDelta;
    logic [9:0]  spareDelta;
    logic        isMain;
    logic        isSpare;

    // ************
    // per word parity contributions
    // ************
    always_comb begin
        wordPar = ^word;
        for (int k = 0; k < 4; k++) begin
            bitPar[2*k+1] = ^(word & FECB_BITSEL[k]);
            bitPar[2*k]   = ^(word & ~FECB_BITSEL[k]);
        end
        mainDelta[7:0] = bitPar;
        for (int k = 0; k < 8; k++) begin
            mainDelta[8+2*k+1] = wordPar & idx[k];
            mainDelta[8+2*k]   = wordPar & ~idx[k];
        end
        spareDelta[7:0] = bitPar;
        spareDelta[9]   = wordPar & (idx == FECB_SP_DATA1);
        spareDelta[8]   = wordPar & (idx == FECB_SP_DATA0);
        isMain  = (idx < FECB_MARK_IDX);
        isSpare = (idx == FECB_SP_DATA0) || (idx == FECB_SP_DATA1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainCode <= '0;
        end else if (clear) begin
            mainCode <= '0;
        end else if (en && isMain) begin
            mainCode <= mainCode ^ mainDelta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spareCode <= '0;
        end else if (clear) begin
            spareCode <= '0;
        end else if (en && isSpare) begin
            spareCode <= spareCode ^ spareDelta;
        end
    end
endmodule

// [rtl/fecb_engine.sv]
// sector ecc engine with bypass, correction and invalid block mark check
`timescale 1ns/1ps
module fecb_engine
    import fecb_pkg::*;
(
    input  wire logic        clk,         // core clock, 250 MHz
    input  wire logic        rst_n,       // async reset, active low
    input  wire logic [15:0] sysCfg1,     // system configuration 1 value
    input  wire logic        opStart,     // start one sector transfer
    input  wire logic        opLoad,      // 1 load, 0 program
    input  wire logic [8:0]  opBlock,     // array block address
    input  wire logic [5:0]  opPage,      // page in block
    input  wire logic [1:0]  opSector,    // sector in page
    output logic             busy,        // transfer in progress
    input  wire logic        inValid,     // source word valid
    input  wire logic [15:0] inData,      // source word
    output logic             inReady,     // engine takes word
    output logic             outValid,    // sink word valid
    output logic      [15:0] outData,     // sink word
    input  wire logic        outReady,    // sink takes word
    output logic      [8:0]  arrayBlock,  // block being accessed
    output logic      [5:0]  arrayPage,   // page being accessed
    output logic             corrValid,   // buffer bit fix pulse
    output logic      [8:0]  corrIndex,   // word index to fix
    output logic      [15:0] corrMask,    // bit to flip
    output logic             eccValid,    // status holds a result
    output logic      [1:0]  eccStatus,   // none, one bit, two bit
    output logic      [8:0]  errIndex,    // error word index
    output logic      [3:0]  errBit,      // error bit position
    output logic             markBad,     // invalid block mark seen
    output logic             loadErr      // uncorrectable load
);
    fecb_state_t state_r;
    logic [8:0]  idx_r;
    logic        load_r;
    logic        bypass_r;
    logic [1:0]  sector_r;
    logic [23:0] storedMain_r;
    logic [9:0]  storedSpare_r;
    logic [23:0] accMain;
    logic [9:0]  accSpare;
    logic        inFire;
    logic        accEn;
    logic [23:0] synM;
    logic [23:0] synS;
    logic        mZero, mSingle, mOne, sZero, sSingle, sOne;
    logic        uncorr;
    logic [11:0] locM;
    logic [11:0] locS;

    // ************
    // syndrome helpers
    // ************
    function automatic logic pairsSingle(input logic [23:0] s, input int n);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 12; k++) begin
            if (k < n && s[2*k] == s[2*k+1]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic oneBit(input logic [23:0] s);
        logic [4:0] c;
        c = '0;
        for (int k = 0; k < 24; k++) begin
            c = c + {4'h0, s[k]};
        end
        return c == 5'h01;
    endfunction

    function automatic logic [11:0] locOf(input logic [23:0] s);
        logic [11:0] l;
        for (int k = 0; k < 12; k++) begin
            l[k] = s[2*k+1];
        end
        return l;
    endfunction

    // ************
    // handshake and code engine
    // ************
    assign busy    = (state_r != S_IDLE);
    assign inReady = (state_r == S_XFER) && (!outValid || outReady);
    assign inFire  = inValid && inReady;
    assign accEn   = inFire && !bypass_r;

    fecb_code_acc u_acc (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (opStart && state_r == S_IDLE),
        .en        (accEn),
        .word      (inData),
        .idx       (idx_r),
        .mainCode  (accMain),
        .spareCode (accSpare)
    );

    always_comb begin
        synM    = storedMain_r ^ accMain;
        synS    = {14'h0, storedSpare_r ^ accSpare};
        mZero   = (synM == '0);
        sZero   = (synS == '0);
        mSingle = pairsSingle(synM, FECB_MAIN_PAIRS);
        sSingle = pairsSingle(synS, FECB_SPARE_PAIRS);
        mOne    = oneBit(synM);
        sOne    = oneBit(synS);
        uncorr  = (!mZero && !mSingle && !mOne) || (!sZero && !sSingle && !sOne);
        locM    = locOf(synM);
        locS    = locOf(synS);
    end

    // ************
    // sequencing
    // ************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= S_IDLE;
            idx_r    <= FECB_IDX_RST;
            load_r   <= 1'b0;
            bypass_r <= 1'b0;
            sector_r <= 2'h0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (opStart) begin
                        state_r  <= S_XFER;
                        idx_r    <= FECB_IDX_RST;
                        load_r   <= opLoad;
                        bypass_r <= sysCfg1[FECB_BYPASS_BIT];
                        sector_r <= opSector;
                    end
                end
                S_XFER: begin
                    if (inFire) begin
                        idx_r <= idx_r + 9'h001;
                        if (idx_r == FECB_LAST_IDX) begin
                            state_r <= (load_r && !bypass_r) ? S_CHECK : S_DRAIN;
                        end
                    end
                end
                S_CHECK: state_r <= S_FIX;
                S_FIX:   state_r <= S_DRAIN;
                S_DRAIN: begin
                    if (!outValid || outReady) begin
                        state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // array address held for the whole sector, only the addressed page is touched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arrayBlock <= FECB_BLOCK0;
            arrayPage  <= '0;
        end else if (state_r == S_IDLE && opStart) begin
            arrayBlock <= opBlock;
            arrayPage  <= opPage;
        end
    end

    // ************
    // data path
    // ************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            outData  <= '0;
        end else if (inFire) begin
            outValid <= 1'b1;
            outData  <= inData;
            if (!load_r && !bypass_r) begin
                unique case (idx_r)
                    FECB_SP_ECC0: outData <= accMain[15:0];
                    FECB_SP_ECC1: outData <= {FECB_PAD8, accMain[23:16]};
                    FECB_SP_ECC2: outData <= {FECB_PAD6, accSpare};
                    default:      outData <= inData;
                endcase
            end
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

    // stored code arrives with the load and is passed on as read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            storedMain_r  <= '0;
            storedSpare_r <= '0;
        end else if (inFire && load_r) begin
            if (idx_r == FECB_SP_ECC0) begin
                storedMain_r[15:0] <= inData;
            end
            if (idx_r == FECB_SP_ECC1) begin
                storedMain_r[23:16] <= inData[7:0];
            end
            if (idx_r == FECB_SP_ECC2) begin
                storedSpare_r <= inData[9:0];
            end
        end
    end

    // ************
    // status, correction and marks
    // ************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eccValid  <= 1'b0;
            eccStatus <= FECB_ST_NONE;
            errIndex  <= '0;
            errBit    <= '0;
            loadErr   <= 1'b0;
        end else if (state_r == S_IDLE && opStart) begin
            eccValid  <= 1'b0;
            eccStatus <= FECB_ST_NONE;
            errIndex  <= '0;
            errBit    <= '0;
            loadErr   <= 1'b0;
        end else if (state_r == S_CHECK) begin
            eccValid <= 1'b1;
            loadErr  <= uncorr;
            if (uncorr) begin
                eccStatus <= FECB_ST_TWO;
            end else if (!mZero || !sZero) begin
                eccStatus <= FECB_ST_ONE;
            end
            if (mSingle && !uncorr) begin
                errIndex <= {1'b0, locM[11:4]};
                errBit   <= locM[3:0];
            end else if (sSingle && !uncorr) begin
                errIndex <= FECB_SP_DATA0 + {8'h0, locS[4]};
                errBit   <= locS[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            corrValid <= 1'b0;
            corrIndex <= '0;
            corrMask  <= '0;
        end else begin
            corrValid <= 1'b0;
            if (state_r == S_CHECK && mSingle && !uncorr) begin
                corrValid <= 1'b1;
                corrIndex <= {1'b0, locM[11:4]};
                corrMask  <= 16'h0001 << locM[3:0];
            end else if (state_r == S_FIX && sSingle && !uncorr) begin
                corrValid <= 1'b1;
                corrIndex <= FECB_SP_DATA0 + {8'h0, locS[4]};
                corrMask  <= 16'h0001 << locS[3:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            markBad <= 1'b0;
        end else if (state_r == S_IDLE && opStart) begin
            markBad <= 1'b0;
        end else if (inFire && load_r && idx_r == FECB_MARK_IDX) begin
            markBad <= (inData != FECB_ERASED) && (arrayBlock != FECB_BLOCK0)
                       && (sector_r == FECB_MARK_SECTOR) && (arrayPage < FECB_MARK_PAGES);
        end
    end

    // ************
    // assertions
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        state_r == S_IDLE && opStart;
    endsequence

    sequence s_checkSingle;
        state_r == S_CHECK && mSingle && !uncorr;
    endsequence

    a_bypass_no_gen: assert property (bypass_r && busy |=> $stable(accMain) && $stable(accSpare))
        else $error("code generated in bypass");
    a_bypass_spare_keep: assert property (inFire && bypass_r |=> outData == $past(inData))
        else $error("bypass altered a written word");
    a_bypass_load_code: assert property (inFire && bypass_r && load_r |=> accMain == $past(accMain))
        else $error("fresh code computed on bypass load");
    a_bypass_status: assert property (bypass_r && load_r && state_r == S_DRAIN |-> !eccValid && errIndex == '0)
        else $error("bypass load left a valid result");
    a_bypass_no_fix: assert property (bypass_r |-> !corrValid && !loadErr)
        else $error("bypass corrected or detected");
    a_mode_select: assert property (s_start |=> bypass_r == $past(sysCfg1[FECB_BYPASS_BIT]))
        else $error("mode not taken from config bit");
    a_load_stored_code: assert property (inFire && load_r |=> outData == $past(inData))
        else $error("load did not pass stored word");
    a_prog_code_out: assert property (inFire && !load_r && !bypass_r && idx_r == FECB_SP_ECC0
        |=> outData == accMain[15:0])
        else $error("program code word wrong");
    a_block0_valid: assert property (markBad |-> arrayBlock != FECB_BLOCK0)
        else $error("block zero reported invalid");
    a_mark_detect: assert property (inFire && load_r && idx_r == FECB_MARK_IDX
        && inData != FECB_ERASED && arrayBlock != FECB_BLOCK0 && sector_r == FECB_MARK_SECTOR
        && arrayPage < FECB_MARK_PAGES |=> markBad)
        else $error("invalid mark missed");
    a_page_held: assert property (busy && !(state_r == S_IDLE) |=> $stable(arrayPage))
        else $error("page changed mid transfer");
    a_single_fix: assert property (s_checkSingle |=> corrValid ##0 eccStatus == FECB_ST_ONE)
        else $error("single error not corrected");
endmodule

// [sim/fecb_engine_tb.sv]
// self-checking bench for the sector ecc engine
`timescale 1ns/1ps
module fecb_engine_tb
    import fecb_pkg::*;
;
    localparam int          N        = int'(FECB_LAST_IDX) + 1;
    localparam logic [15:0] CFG_NORM = 16'hfdff;
    localparam logic [15:0] CFG_BYP  = 16'h0200;
    logic        clk, rst_n, opStart, opLoad, busy, inValid, inReady, outValid, outReady;
    logic        corrValid, eccValid, markBad, loadErr, stall;
    logic [15:0] sysCfg1, inData, outData, corrMask;
    logic [8:0]  opBlock, arrayBlock, corrIndex, errIndex;
    logic [5:0]  opPage, arrayPage;
    logic [1:0]  opSector, eccStatus;
    logic [3:0]  errBit;
    logic [15:0] pat [N];
    logic [15:0] gc  [3];
    int          num_errors = 0;
    int          num_checks = 0;
    logic [511:0] badTbl    = '0;

    fecb_engine u_fecb_engine (.clk(clk), .rst_n(rst_n), .sysCfg1(sysCfg1), .opStart(opStart),
        .opLoad(opLoad), .opBlock(opBlock), .opPage(opPage), .opSector(opSector), .busy(busy),
        .inValid(inValid), .inData(inData), .inReady(inReady), .outValid(outValid),
        .outData(outData), .outReady(outReady), .arrayBlock(arrayBlock), .arrayPage(arrayPage),
        .corrValid(corrValid), .corrIndex(corrIndex), .corrMask(corrMask), .eccValid(eccValid),
        .eccStatus(eccStatus), .errIndex(errIndex), .errBit(errBit), .markBad(markBad),
        .loadErr(loadErr));
    fecb_host_model u_fecb_host_model (.clk(clk), .rst_n(rst_n), .stall(stall),
        .inValid(inValid), .inData(inData), .inReady(inReady), .outValid(outValid),
        .outData(outData), .outReady(outReady), .corrValid(corrValid),
        .corrIndex(corrIndex), .corrMask(corrMask));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic fill;
        for (int n = 0; n < N; n++) pat[n] = 16'(n * 37) ^ 16'ha5c3;
        pat[FECB_MARK_IDX] = FECB_ERASED;
    endtask

    // host table lookup: programs to a listed block go to a spare block
    function automatic logic [8:0] remap(input logic [8:0] blk);
        return badTbl[blk] ? (blk | 9'h100) : blk;
    endfunction

    // one sector through the engine, waits for busy to drop under a bound
    task automatic run_op(input logic ld, input logic [15:0] cfg, input logic [8:0] blk,
                          input logic [5:0] pg, input logic [1:0] sec);
        int n;
        logic [8:0] blkUse;
        blkUse = ld ? blk : remap(blk);
        @(negedge clk);
        sysCfg1  = cfg;
        opLoad   = ld;
        opBlock  = blkUse;
        opPage   = pg;
        opSector = sec;
        opStart  = 1'b1;
        for (n = 0; n < N; n++) u_fecb_host_model.srcBuf[n] = pat[n];
        u_fecb_host_model.rearm();
        @(negedge clk);
        opStart = 1'b0;
        chk(16'(busy), 16'h0001);
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 3000) begin
            num_errors++;
            test_done();
        end
        chk(16'(u_fecb_host_model.sinkIdx), 16'(N));
        chk(16'(arrayBlock), 16'(blkUse));
        chk(16'(arrayPage), 16'(pg));
    endtask

    task automatic chk_sink(input int lo, input int hi);
        for (int n = 0; n < N; n++) begin
            if (n < lo || n > hi) chk(u_fecb_host_model.sinkBuf[n], pat[n]);
        end
    endtask

    task automatic load_with(input logic [15:0] cfg, input int i1, input int b1,
                             input int i2, input int b2);
        fill();
        for (int k = 0; k < 3; k++) pat[259 + k] = gc[k];
        if (i1 >= 0) pat[i1][b1] = ~pat[i1][b1];
        if (i2 >= 0) pat[i2][b2] = ~pat[i2][b2];
        run_op(1'b1, cfg, 9'h007, 6'h05, 2'h2);
        chk_sink(-1, -1);
    endtask

    task automatic t_prog_normal;
        fill();
        for (int k = 0; k < 3; k++) pat[259 + k] = 16'h1234;
        run_op(1'b0, CFG_NORM, 9'h003, 6'h04, 2'h1);
        chk_sink(259, 261);
        for (int k = 0; k < 3; k++) gc[k] = u_fecb_host_model.sinkBuf[259 + k];
        chk(16'(gc[1][15:8]), 16'(FECB_PAD8));
        chk(16'(gc[2][15:10]), 16'(FECB_PAD6));
        chk(16'(u_fecb_host_model.corrCnt), 16'h0000);
        chk(16'(eccValid), 16'h0000);
        $display("test prog_normal done");
    endtask

    task automatic t_prog_bypass;
        stall = 1'b1;
        run_op(1'b0, CFG_BYP, 9'h004, 6'h3f, 2'h3);
        chk_sink(-1, -1);
        stall = 1'b0;
        $display("test prog_bypass done");
    endtask

    task automatic t_load_clean;
        load_with(CFG_NORM, -1, 0, -1, 0);
        chk(16'(eccValid), 16'h0001);
        chk(16'(eccStatus), 16'(FECB_ST_NONE));
        chk(16'(loadErr), 16'h0000);
        chk(16'(u_fecb_host_model.corrCnt), 16'h0000);
        $display("test load_clean done");
    endtask

    task automatic t_load_main1;
        load_with(CFG_NORM, 17, 5, -1, 0);
        chk(16'(eccStatus), 16'(FECB_ST_ONE));
        chk(16'(u_fecb_host_model.corrCnt), 16'h0001);
        chk(16'(u_fecb_host_model.corrIdx), 16'h0011);
        chk(u_fecb_host_model.corrMsk, 16'h0020);
        chk(16'(errIndex), 16'h0011);
        chk(16'(errBit), 16'h0005);
        chk(16'(loadErr), 16'h0000);
        $display("test load_main1 done");
    endtask

    task automatic t_load_spare1;
        load_with(CFG_NORM, 258, 3, -1, 0);
        chk(16'(eccStatus), 16'(FECB_ST_ONE));
        chk(16'(u_fecb_host_model.corrIdx), 16'(FECB_SP_DATA1));
        chk(u_fecb_host_model.corrMsk, 16'h0008);
        $display("test load_spare1 done");
    endtask

    task automatic t_load_double;
        load_with(CFG_NORM, 17, 5, 200, 9);
        chk(16'(eccStatus), 16'(FECB_ST_TWO));
        chk(16'(loadErr), 16'h0001);
        chk(16'(u_fecb_host_model.corrCnt), 16'h0000);
        $display("test load_double done");
    endtask

    task automatic t_load_bypass;
        load_with(CFG_BYP, 17, 5, -1, 0);
        chk(16'(eccValid), 16'h0000);
        chk(16'(eccStatus), 16'(FECB_ST_NONE));
        chk(16'(errIndex), 16'h0000);
        chk(16'(loadErr), 16'h0000);
        chk(16'(u_fecb_host_model.corrCnt), 16'h0000);
        $display("test load_bypass done");
    endtask

    task automatic t_mark;
        logic [16:0] tbl [5];
        tbl = '{{9'h005, 6'h00, 2'h0}, {9'h005, 6'h01, 2'h0}, {9'h000, 6'h01, 2'h0},
                {9'h005, 6'h02, 2'h0}, {9'h005, 6'h01, 2'h1}};
        for (int t = 0; t < 5; t++) begin
            fill();
            for (int k = 0; k < 3; k++) pat[259 + k] = gc[k];
            pat[FECB_MARK_IDX] = 16'h0000;
            run_op(1'b1, CFG_NORM, tbl[t][16:8], tbl[t][7:2], tbl[t][1:0]);
            chk(16'(markBad), 16'(t < 2));
            if (markBad === 1'b1) badTbl[tbl[t][16:8]] = 1'b1;
        end
        chk(16'(badTbl[9'h000]), 16'h0000);
        chk(16'(badTbl[9'h005]), 16'h0001);
        run_op(1'b0, CFG_NORM, 9'h005, 6'h00, 2'h0);
        chk(16'(arrayBlock), 16'h0105);
        $display("test mark done");
    endtask

    // array reports a program status failure at page 2 of block 6
    task automatic t_replace;
        fill();
        for (int k = 0; k < 3; k++) pat[259 + k] = gc[k];
        badTbl[9'h006] = 1'b1;
        for (int p = 0; p < 2; p++) begin
            run_op(1'b1, CFG_NORM, 9'h006, 6'(p), 2'h0);
            chk(16'(eccStatus), 16'(FECB_ST_NONE));
            chk(16'(loadErr), 16'h0000);
            run_op(1'b0, CFG_NORM, 9'h006, 6'(p), 2'h0);
            chk(16'(arrayBlock), 16'h0106);
        end
        run_op(1'b0, CFG_NORM, 9'h006, 6'h02, 2'h0);
        chk(16'(arrayBlock), 16'h0106);
        chk(16'(arrayPage), 16'h0002);
        $display("test replace done");
    endtask

    initial begin
        {rst_n, opStart, opLoad, stall} = 4'h0;
        sysCfg1  = 16'h0000;
        opBlock  = 9'h000;
        opPage   = 6'h00;
        opSector = 2'h0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        chk(16'({busy, inReady, outValid, eccValid, markBad, loadErr}), 16'h0000);
        t_prog_normal();
        t_prog_bypass();
        t_load_clean();
        t_load_main1();
        t_load_spare1();
        t_load_double();
        t_load_bypass();
        t_mark();
        t_replace();
        test_done();
    end
endmodule

// [sim/fecb_host_model.sv]
// host stream model: sector source, sink capture and correction log
`timescale 1ns/1ps
module fecb_host_model
    import fecb_pkg::*;
(
    input  wire logic        clk,        // core clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic        stall,      // sink takes every other cycle
    output logic             inValid,    // source word valid
    output logic      [15:0] inData,     // source word
    input  wire logic        inReady,    // engine takes word
    input  wire logic        outValid,   // sink word valid
    input  wire logic [15:0] outData,    // sink word
    output logic             outReady,   // sink takes word
    input  wire logic        corrValid,  // fix pulse
    input  wire logic [8:0]  corrIndex,  // word to fix
    input  wire logic [15:0] corrMask    // bit to flip
);
    localparam int N = int'(FECB_LAST_IDX) + 1;
    logic [15:0] srcBuf  [N];
    logic [15:0] sinkBuf [N];
    int          srcIdx  = 0;
    int          sinkIdx = 0;
    int          corrCnt = 0;
    int          cyc     = 0;
    logic [8:0]  corrIdx = 9'h000;
    logic [15:0] corrMsk = 16'h0000;
    logic        armed   = 1'b0;
    logic        took    = 1'b0;

    initial begin
        inValid  = 1'b0;
        inData   = 16'h0000;
        outReady = 1'b0;
    end

    // load errors never stop the model from streaming further sectors
    task automatic rearm;
        srcIdx  = 0;
        sinkIdx = 0;
        corrCnt = 0;
        armed   = 1'b1;
    endtask

    always @(posedge clk) begin
        took = inValid && inReady;
        if (outValid && outReady && sinkIdx < N) begin
            sinkBuf[sinkIdx] = outData;
            sinkIdx = sinkIdx + 1;
        end
        if (corrValid) begin
            corrCnt = corrCnt + 1;
            corrIdx = corrIndex;
            corrMsk = corrMask;
        end
    end

    always @(negedge clk) begin
        cyc = cyc + 1;
        if (took) srcIdx = srcIdx + 1;
        took = 1'b0;
        outReady = rst_n && !(stall && cyc[0]);
        if (rst_n && armed && srcIdx < N) begin
            inValid = 1'b1;
            inData  = srcBuf[srcIdx];
        end else begin
            // released data line toggles so a stale word is never seen
            inValid = 1'b0;
            inData  = ~inData;
        end
    end
endmodule
